// File: hw/dic_top.sv
// Digital input conditioner: scan timing, per-input conditioning and pipelined outputs.
// Behaviour
// - Every input is sampled once per 5 ms scan, so a terminal change shows within 0 to 5 ms.
// - A per-input polarity picks whether an energized terminal reads 1 or 0, normally-open by default.
// - A per-input activation delay in 1 ms steps, default zero, delays every 0 to 1 change.
// - A per-input drop-off delay in 1 ms steps, default zero, delays every 1 to 0 change.
// - Per-input AC mode, off by default, adds a fixed 30 ms hold before release.
// - Internal consumers see an updated input one scan round later, up to 10 ms in total.
// - An input routed to a digital output takes one more round, up to 15 ms in total.
// - Digital output drive states update once per 5 ms cycle, with the input scan.
`timescale 1ns/1ps
`default_nettype none
module dic_top #(
   parameter int unsigned N    = dic_pkg::NUM_INPUTS,
   parameter int unsigned M    = dic_pkg::NUM_OUTPUTS,
   parameter int unsigned DW   = dic_pkg::DELAY_W,
   parameter int unsigned SCAN = dic_pkg::SCAN_CYCLES
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [N-1:0]     digital_input_n,
   input  wire logic [N-1:0]     polarity,
   input  wire logic [N*DW-1:0]  act_delay_ms,
   input  wire logic [N*DW-1:0]  drop_delay_ms,
   input  wire logic [N-1:0]     ac_mode,
   input  wire logic [M*N-1:0]   output_route,
   input  wire logic [M-1:0]     output_force,
   output logic     [N-1:0]     input_state,
   output logic     [N-1:0]     logic_state,
   output logic     [M-1:0]     digital_output_n,
   output logic                 scan_strobe
);
   typedef struct packed {
      logic [31:0]  scan_cnt;
      logic         tick;
      logic [N-1:0] in_state;
      logic [N-1:0] logic_st;
      logic [M-1:0] out_st;
   } dic_top_s;

   dic_top_s     st_r;
   dic_top_s     st_nxt;
   logic [1:0]   rst_sync_r;
   logic         rst_q_n;
   logic [N-1:0] ch_state;
   logic [M-1:0] route_val;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_q_n = rst_sync_r[1];

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_ch
         dic_channel #(.DW(DW)) u_ch (
            .core_clk      (core_clk),
            .rst_q_n       (rst_q_n),
            .scan_tick     (st_r.tick),
            .raw_in        (digital_input_n[gi]),
            .polarity      (polarity[gi]),
            .act_delay_ms  (act_delay_ms[gi*DW +: DW]),
            .drop_delay_ms (drop_delay_ms[gi*DW +: DW]),
            .ac_mode       (ac_mode[gi]),
            .state         (ch_state[gi])
         );
      end
      for (gi = 0; gi < M; gi++)
      begin : g_route
         assign route_val[gi] = output_force[gi] | (|(output_route[gi*N +: N] & st_r.logic_st));
      end
   endgenerate

   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.scan_cnt == 32'(SCAN - 1))
      begin
         st_nxt.scan_cnt = '0;
         st_nxt.tick     = 1'b1;
      end
      else
      begin
         st_nxt.scan_cnt = st_r.scan_cnt + 32'h1;
      end
      // The conditioned states are copied on every cycle, so a change sampled on a tick shows
      // within that same scan round; the logic and output stages then add one round each.
      st_nxt.in_state = ch_state;
      if (st_r.tick)
      begin
         st_nxt.logic_st = st_r.in_state;
         st_nxt.out_st   = route_val;
      end
   end

   always_ff @(posedge core_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign input_state      = st_r.in_state;
   assign logic_state      = st_r.logic_st;
   assign digital_output_n = st_r.out_st;
   assign scan_strobe      = st_r.tick;

   a_scan_period: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      st_r.tick |=> !st_r.tick [*8])
      else $error("Scan ticks came too close together.");
   a_tick_count: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      st_r.tick |-> st_r.scan_cnt == '0)
      else $error("Scan tick out of step with counter.");
   a_logic_follows: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      st_r.tick |=> st_r.logic_st == $past(st_r.in_state))
      else $error("Logic state did not take the previous round.");
   a_output_update: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      !st_r.tick |=> $stable(st_r.out_st))
      else $error("Outputs changed off a scan round.");
   a_output_route: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      st_r.tick |=> st_r.out_st == $past(route_val))
      else $error("Outputs missed the routed logic state.");
   c_input_rise: cover property (@(posedge core_clk) disable iff (!rst_q_n)
      $rose(st_r.in_state[0]));
   c_logic_rise: cover property (@(posedge core_clk) disable iff (!rst_q_n)
      $rose(st_r.logic_st[0]));
   c_output_rise: cover property (@(posedge core_clk) disable iff (!rst_q_n)
      $rose(st_r.out_st[0]));
endmodule
`default_nettype wire

// File: hw/dic_pkg.sv
// Constants of the digital input conditioner.
package dic_pkg;
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned SCAN_PERIOD_US  = 5000;
   localparam int unsigned SCAN_CYCLES     = (CLK_HZ / 1000000) * SCAN_PERIOD_US;
   localparam int unsigned TICK_MS_US      = 1000;
   localparam int unsigned MS_CYCLES       = (CLK_HZ / 1000000) * TICK_MS_US;
   localparam int unsigned SCAN_MS         = SCAN_PERIOD_US / TICK_MS_US;
   localparam int unsigned AC_HOLD_MS      = 30;
   localparam int unsigned DELAY_W         = 21;
   localparam int unsigned NUM_INPUTS      = 3;
   localparam int unsigned NUM_OUTPUTS     = 5;
   localparam logic        POL_NO          = 1'b0;
   localparam logic        POL_NC          = 1'b1;
   localparam logic [20:0] DELAY_RESET     = 21'h000000;
endpackage

// File: hw/dic_channel.sv
// One input channel: polarity, activation, drop-off and AC hold timers.
`timescale 1ns/1ps
`default_nettype none
module dic_channel #(
   parameter int unsigned DW = dic_pkg::DELAY_W
) (
   input  wire logic          core_clk,
   input  wire logic          rst_q_n,
   input  wire logic          scan_tick,
   input  wire logic          raw_in,
   input  wire logic          polarity,
   input  wire logic [DW-1:0] act_delay_ms,
   input  wire logic [DW-1:0] drop_delay_ms,
   input  wire logic          ac_mode,
   output logic               state
);
   typedef struct packed {
      logic          state;
      logic [DW-1:0] elapsed;
   } dic_ch_s;

   dic_ch_s st_r;
   dic_ch_s st_nxt;
   logic          level;
   logic [DW-1:0] need;
   logic [DW-1:0] ac_ms;
   logic [DW-1:0] step;

   assign ac_ms = DW'(dic_pkg::AC_HOLD_MS);
   assign step  = DW'(dic_pkg::SCAN_MS);

   always_comb
   begin
      st_nxt = st_r;
      level  = raw_in ^ (polarity == dic_pkg::POL_NC);
      need   = st_r.state ? drop_delay_ms + (ac_mode ? ac_ms : '0) : act_delay_ms;
      if (scan_tick)
      begin
         if (level == st_r.state)
         begin
            st_nxt.elapsed = '0;
         end
         else if (st_r.elapsed >= need)
         begin
            st_nxt.state   = level;
            st_nxt.elapsed = '0;
         end
         else
         begin
            st_nxt.elapsed = st_r.elapsed + step;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_q_n)
   begin
      if (!rst_q_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign state = st_r.state;

   a_zero_delay_follow: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      scan_tick && act_delay_ms == '0 && !st_r.state && level |=> st_r.state)
      else $error("Zero activation delay did not switch on the scan.");
   a_hold_between_ticks: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      !scan_tick |=> $stable(st_r.state))
      else $error("Channel state changed off a scan tick.");
   a_drop_waits_delay: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      scan_tick && st_r.state && !level && st_r.elapsed < need |=> st_r.state)
      else $error("Drop-off happened before its delay.");
   a_ac_hold_keeps: assert property (@(posedge core_clk) disable iff (!rst_q_n)
      scan_tick && ac_mode && st_r.state && st_r.elapsed < ac_ms |=> st_r.state)
      else $error("AC mode released inside the hold.");
   c_channel_rise: cover property (@(posedge core_clk) disable iff (!rst_q_n)
      $rose(st_r.state));
   c_channel_ac_fall: cover property (@(posedge core_clk) disable iff (!rst_q_n)
      ac_mode && $fell(st_r.state));
endmodule
`default_nettype wire

// File: dv/dic_field_model.sv
// Field wiring model: energizes the input terminals when commanded.
`timescale 1ns/1ps
`default_nettype none
module dic_field_model #(
   parameter int unsigned N = dic_pkg::NUM_INPUTS
) (
   input  wire logic         core_clk,
   input  wire logic [N-1:0] energize,
   output var  logic [N-1:0] digital_input_n
);
   initial digital_input_n = '0;
   // A terminal changes level only just after a clock edge.
   always @(posedge core_clk)
      digital_input_n <= energize;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Testbench of the digital input conditioner.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned N    = dic_pkg::NUM_INPUTS;
   localparam int unsigned M    = dic_pkg::NUM_OUTPUTS;
   localparam int unsigned DW   = dic_pkg::DELAY_W;
   localparam int unsigned SCAN = 10;
   logic              core_clk      = 1'b0;
   logic              rst_n         = 1'b0;
   logic [N-1:0]      energize      = '0;
   logic [N-1:0]      polarity      = '0;
   logic [N*DW-1:0]   act_delay_ms  = '0;
   logic [N*DW-1:0]   drop_delay_ms = '0;
   logic [N-1:0]      ac_mode       = '0;
   logic [M*N-1:0]    output_route  = '0;
   logic [M-1:0]      output_force  = '0;
   logic [N-1:0]      digital_input_n;
   logic [N-1:0]      input_state;
   logic [N-1:0]      logic_state;
   logic [M-1:0]      digital_output_n;
   logic              scan_strobe;
   int                err_total     = 0;
   int                n_tests       = 0;
   always #12.5 core_clk = ~core_clk;
   dic_field_model #(.N(N)) dic_field_model_i (.core_clk(core_clk), .energize(energize),
      .digital_input_n(digital_input_n));
   dic_top #(.SCAN(SCAN)) dic_top_i (.core_clk(core_clk), .rst_n(rst_n),
      .digital_input_n(digital_input_n), .polarity(polarity), .act_delay_ms(act_delay_ms),
      .drop_delay_ms(drop_delay_ms), .ac_mode(ac_mode), .output_route(output_route),
      .output_force(output_force), .input_state(input_state), .logic_state(logic_state),
      .digital_output_n(digital_output_n), .scan_strobe(scan_strobe));
   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Waits for n scan ticks, then lets the updates of that tick settle.
   task automatic ticks(input int n);
      int seen;
      int lim;
      seen = 0;
      lim = 0;
      while (seen < n && lim < n * SCAN * 2 + 4)
      begin
         @(posedge core_clk);
         #1;
         lim++;
         if (scan_strobe === 1'b1)
            seen++;
      end
      if (seen < n)
      begin
         err_total++;
         $display("Error scan_strobe expected tick seen none");
         report_and_stop();
      end
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic t_polarity();
      chk("input_state after reset", 1'b0, input_state[1]);
      @(posedge core_clk) polarity[1] <= 1'b1;
      ticks(2);
      chk("nc idle state", 1'b1, input_state[1]);
      @(posedge core_clk) energize[1] <= 1'b1;
      ticks(2);
      chk("nc energized state", 1'b0, input_state[1]);
      $display("test polarity done");
   endtask
   task automatic t_pipeline();
      @(posedge core_clk);
      output_route[0] <= 1'b1;
      output_force[4] <= 1'b1;
      ticks(1);
      @(posedge core_clk) energize[0] <= 1'b1;
      ticks(1);
      chk("no energized state", 1'b1, input_state[0]);
      chk("logic one round late", 1'b0, logic_state[0]);
      ticks(1);
      chk("logic state", 1'b1, logic_state[0]);
      chk("output one round late", 1'b0, digital_output_n[0]);
      ticks(1);
      chk("routed output", 1'b1, digital_output_n[0]);
      chk("forced output", 1'b1, digital_output_n[4]);
      $display("test pipeline done");
   endtask
   task automatic t_delays();
      @(posedge core_clk);
      act_delay_ms[2*DW+:DW] <= 21'h00000A;
      drop_delay_ms[0+:DW] <= 21'h00000A;
      ac_mode[2] <= 1'b1;
      energize[2] <= 1'b1;
      ticks(1);
      chk("activation held", 1'b0, input_state[2]);
      ticks(3);
      chk("activation done", 1'b1, input_state[2]);
      @(posedge core_clk) energize <= 3'h2;
      ticks(1);
      chk("drop-off held", 1'b1, input_state[0]);
      ticks(2);
      chk("drop-off done", 1'b0, input_state[0]);
      ticks(2);
      chk("ac hold", 1'b1, input_state[2]);
      ticks(3);
      chk("ac release", 1'b0, input_state[2]);
      $display("test delays done");
   endtask
   task automatic t_reset();
      int gap;
      gap = 0;
      @(posedge core_clk) rst_n <= 1'b0;
      #1;
      chk("output in reset", 1'b0, digital_output_n[4]);
      @(posedge core_clk) rst_n <= 1'b1;
      ticks(1);
      chk("output after reset", 1'b1, digital_output_n[4]);
      // The wait above returns two edges after the strobe.
      while (scan_strobe !== 1'b1 && gap < SCAN * 2)
      begin
         @(posedge core_clk);
         #1;
         gap++;
      end
      chk("scan period", 1'b1, gap + 2 == SCAN);
      $display("test reset done");
   endtask
   initial
   begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      t_polarity();
      t_pipeline();
      t_delays();
      t_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
